/* rtl/tmr16_timer.sv */
// Contract
// - wait mode leaves the timer running; enabled interrupts wake it
// - halt stops the counter; it resumes from held value
// - capture edge in halt arms; wake sets flag and captures exit count
// - capture enable passes either capture flag to the interrupt
// - compare enable passes either compare flag to the interrupt
// - overflow enable passes the overflow flag to the interrupt
// - forced compare two copies level two to enabled pin two
// - forced compare one copies level one to enabled pin one
// - level two goes to pin two on match; pin one in pulse modes
// - capture one edge: 0 falling, 1 rising
// - level one goes to enabled pin one on compare one match
// - pin one enable only routes the pin; compare one keeps running
// - pin two enable only routes the pin; compare two keeps running
// - one pulse mode: capture one edge starts pulse sized by compare one
// - pwm mode: pulse from compare one, period from compare two
// - clock select: div4, div2, div8, external pin
// - without external pin, external setting stops the counter
// - capture two edge: 0 falling, 1 rising
// - external clock edge: 0 falling, 1 rising
// - pwm: capture one flag marks period reset; no compare events
// - flag clears after status read then low byte access
// - pulse trigger captures, reloads fffc, drives level two, sets flag
// - compare high write inhibits compare until low byte written
//
// The AHB-Lite interface to the registers and the placing of the registers were decided locally.
`default_nettype none
module tmr16_timer #(
    parameter bit HAS_EXT_PIN = 1'b1
) (
    input  wire logic        ref_clk_in,
    input  wire logic        srst_in,
    input  wire logic        hsel_in,
    input  wire logic [31:0] haddr_in,
    input  wire logic [1:0]  htrans_in,
    input  wire logic        hwrite_in,
    input  wire logic [2:0]  hsize_in,
    input  wire logic [31:0] hwdata_in,
    input  wire logic        hready_in,
    output logic [31:0]      hrdata_out,
    output logic             hreadyout_out,
    output logic             hresp_out,
    input  wire logic        capture_one_pin_in,
    input  wire logic        capture_two_pin_in,
    input  wire logic        external_count_pin_in,
    input  wire logic        wait_mode_in,
    input  wire logic        halt_mode_in,
    output logic             compare_one_pin_out,
    output logic             compare_one_pin_oe_out,
    output logic             compare_two_pin_out,
    output logic             compare_two_pin_oe_out,
    output logic             timer_irq_out
);
    // ==========================================================
    // bus slave
    logic       ap_ff;
    logic       apw_ff;
    logic [7:0] apa_ff;
    logic       take;
    logic       wr;
    logic       rd;

    assign take = hsel_in && hready_in && (htrans_in == tmr16_pkg::HTRANS_NSEQ);
    assign wr   = ap_ff && apw_ff;
    assign rd   = take && !hwrite_in;

    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            ap_ff  <= 1'b0;
            apw_ff <= 1'b0;
            apa_ff <= 8'h00;
        end else begin
            ap_ff  <= take;
            apw_ff <= hwrite_in;
            apa_ff <= haddr_in[7:0];
        end
    end

    logic [7:0]  ctrl_one_ff;
    logic [7:0]  ctrl_two_ff;
    logic        disable_ff;
    logic [15:0] cmp_one_ff;
    logic [15:0] cmp_two_ff;
    logic [1:0]  cmp_inh_ff;
    logic [15:0] cnt_ff;
    logic [15:0] cap_one_ff;
    logic [15:0] cap_two_ff;
    logic [7:0]  hi_latch_ff;
    logic [1:0]  power_ff;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction

    // control registers
    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            ctrl_one_ff <= tmr16_pkg::CTRL_RST;
            ctrl_two_ff <= tmr16_pkg::CTRL_RST;
            disable_ff  <= 1'b0;
            power_ff    <= 2'h0;
        end else if (wr) begin
            if (hit(apa_ff, tmr16_pkg::CTRL_ONE_OFF)) begin
                ctrl_one_ff <= hwdata_in[7:0];
            end else if (hit(apa_ff, tmr16_pkg::CTRL_TWO_OFF)) begin
                ctrl_two_ff <= hwdata_in[7:0];
            end else if (hit(apa_ff, tmr16_pkg::STATUS_OFF)) begin
                disable_ff <= hwdata_in[2];
            end else if (hit(apa_ff, tmr16_pkg::POWER_OFF)) begin
                power_ff <= hwdata_in[1:0];
            end
        end
    end

    logic       opm_on;
    logic       pwm_on;
    logic [1:0] clk_sel;
    logic       halted;
    assign pwm_on  = ctrl_two_ff[tmr16_pkg::C2_PWM];
    assign opm_on  = ctrl_two_ff[tmr16_pkg::C2_OPM] && !pwm_on;
    assign clk_sel = ctrl_two_ff[tmr16_pkg::C2_CLK_HI:tmr16_pkg::C2_CLK_LO];
    // wait has no effect on the timer
    assign halted  = power_ff[tmr16_pkg::PW_HALT] || halt_mode_in;

    // compare registers; high write inhibits until low write
    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            cmp_one_ff <= tmr16_pkg::CMP_RST;
            cmp_two_ff <= tmr16_pkg::CMP_RST;
            cmp_inh_ff <= 2'h0;
        end else if (wr) begin
            if (hit(apa_ff, tmr16_pkg::CMP_ONE_HI_OFF)) begin
                cmp_one_ff[15:8] <= hwdata_in[7:0];
                cmp_inh_ff[0]    <= 1'b1;
            end else if (hit(apa_ff, tmr16_pkg::CMP_ONE_LO_OFF)) begin
                cmp_one_ff[7:0] <= hwdata_in[7:0];
                cmp_inh_ff[0]   <= 1'b0;
            end else if (hit(apa_ff, tmr16_pkg::CMP_TWO_HI_OFF)) begin
                cmp_two_ff[15:8] <= hwdata_in[7:0];
                cmp_inh_ff[1]    <= 1'b1;
            end else if (hit(apa_ff, tmr16_pkg::CMP_TWO_LO_OFF)) begin
                cmp_two_ff[7:0] <= hwdata_in[7:0];
                cmp_inh_ff[1]   <= 1'b0;
            end
        end
    end

    // ==========================================================
    // prescaler and external clock
    logic [2:0] pre_ff;
    logic       ext_hit;
    logic       tick;
    logic       run;

    tmr16_edge u_ext_edge (
        .ref_clk_in (ref_clk_in),
        .srst_in    (srst_in),
        .sig_in     (external_count_pin_in),
        .rise_in    (ctrl_two_ff[tmr16_pkg::C2_XEDGE]),
        .hit_out    (ext_hit)
    );

    assign run = !halted && !disable_ff;

    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            pre_ff <= 3'h0;
        end else if (run) begin
            pre_ff <= pre_ff + 3'h1;
        end
    end

    always_comb begin
        tick = 1'b0;
        if (run) begin
            case (clk_sel)
                tmr16_pkg::CLK_DIV4: tick = (pre_ff[1:0] == 2'h3);
                tmr16_pkg::CLK_DIV2: tick = pre_ff[0];
                tmr16_pkg::CLK_DIV8: tick = (pre_ff == 3'h7);
                default:             tick = HAS_EXT_PIN && ext_hit;
            endcase
        end
    end

    // ==========================================================
    // capture edges, halt arming
    logic       cap1_edge;
    logic       cap2_edge;
    logic [1:0] armed_ff;
    logic       halted_q_ff;
    logic       wake;
    logic       cap1_ev;
    logic       cap2_ev;

    tmr16_edge u_cap1_edge (
        .ref_clk_in (ref_clk_in),
        .srst_in    (srst_in),
        .sig_in     (capture_one_pin_in),
        .rise_in    (ctrl_one_ff[tmr16_pkg::C1_EDGE1]),
        .hit_out    (cap1_edge)
    );

    tmr16_edge u_cap2_edge (
        .ref_clk_in (ref_clk_in),
        .srst_in    (srst_in),
        .sig_in     (capture_two_pin_in),
        .rise_in    (ctrl_two_ff[tmr16_pkg::C2_EDGE2]),
        .hit_out    (cap2_edge)
    );

    assign wake = halted_q_ff && !halted;

    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            halted_q_ff <= 1'b0;
            armed_ff    <= 2'h0;
        end else begin
            halted_q_ff <= halted;
            if (halted) begin
                armed_ff <= armed_ff | {cap2_edge, cap1_edge};
            end else begin
                armed_ff <= 2'h0;
            end
        end
    end

    // edges during halt are held back until the wake
    assign cap1_ev = (!halted && cap1_edge) || (wake && armed_ff[0]);
    assign cap2_ev = (!halted && cap2_edge) || (wake && armed_ff[1]);

    // ==========================================================
    // counter, compares, captures
    logic m1;
    logic m2;
    logic ovf;
    logic pwm_end;
    logic opm_trig;
    logic wr_cnt_lo;

    assign m1        = tick && !cmp_inh_ff[0] && (cnt_ff == cmp_one_ff);
    assign m2        = tick && !cmp_inh_ff[1] && (cnt_ff == cmp_two_ff);
    assign ovf       = tick && (cnt_ff == 16'hffff);
    assign pwm_end   = pwm_on && m2;
    assign opm_trig  = opm_on && cap1_ev;
    assign wr_cnt_lo = wr && hit(apa_ff, tmr16_pkg::CNT_LO_OFF);

    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            cnt_ff <= tmr16_pkg::CNT_RST;
        end else if (wr_cnt_lo || pwm_end) begin
            cnt_ff <= tmr16_pkg::CNT_RST;
        end else if (opm_trig) begin
            cnt_ff <= tmr16_pkg::OPM_RELOAD;
        end else if (tick) begin
            cnt_ff <= cnt_ff + 16'h0001;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            cap_one_ff <= 16'h0000;
            cap_two_ff <= 16'h0000;
        end else begin
            if (cap1_ev && !pwm_on) begin
                cap_one_ff <= cnt_ff;
            end
            if (cap2_ev) begin
                cap_two_ff <= cnt_ff;
            end
        end
    end

    // ==========================================================
    // status flags
    logic         st_rd;
    tmr16_pkg::flags_s flags;
    tmr16_pkg::flags_s set_v;
    tmr16_pkg::flags_s low_acc;

    assign st_rd = rd && hit(haddr_in[7:0], tmr16_pkg::STATUS_OFF);

    assign set_v.cap_one = pwm_on ? pwm_end : cap1_ev;
    assign set_v.cmp_one = m1 && !pwm_on && !opm_on && !ctrl_one_ff[tmr16_pkg::C1_FORCE1];
    assign set_v.ovf     = ovf;
    assign set_v.cap_two = cap2_ev;
    assign set_v.cmp_two = m2 && !pwm_on && !ctrl_one_ff[tmr16_pkg::C1_FORCE2];

    assign low_acc.cap_one = take && hit(haddr_in[7:0], tmr16_pkg::CAP_ONE_LO_OFF);
    assign low_acc.cmp_one = take && hit(haddr_in[7:0], tmr16_pkg::CMP_ONE_LO_OFF);
    assign low_acc.ovf     = take && hit(haddr_in[7:0], tmr16_pkg::CNT_LO_OFF);
    assign low_acc.cap_two = take && hit(haddr_in[7:0], tmr16_pkg::CAP_TWO_LO_OFF);
    assign low_acc.cmp_two = take && hit(haddr_in[7:0], tmr16_pkg::CMP_TWO_LO_OFF);

    genvar gi;
    generate
        for (gi = 0; gi < 5; gi++) begin : g_flag
            tmr16_flag u_flag (
                .ref_clk_in   (ref_clk_in),
                .srst_in      (srst_in),
                .set_in       (set_v[gi]),
                .status_rd_in (st_rd),
                .low_acc_in   (low_acc[gi]),
                .flag_out     (flags[gi])
            );
        end
    endgenerate

    // ==========================================================
    // compare pins
    logic out1_ff;
    logic out2_ff;

    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            out1_ff <= 1'b0;
        end else if (pwm_on || opm_on) begin
            if (opm_trig || pwm_end) begin
                out1_ff <= ctrl_one_ff[tmr16_pkg::C1_LVL2];
            end else if (m1) begin
                out1_ff <= ctrl_one_ff[tmr16_pkg::C1_LVL1];
            end
        end else if (ctrl_one_ff[tmr16_pkg::C1_FORCE1]) begin
            out1_ff <= ctrl_one_ff[tmr16_pkg::C1_LVL1];
        end else if (m1) begin
            out1_ff <= ctrl_one_ff[tmr16_pkg::C1_LVL1];
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            out2_ff <= 1'b0;
        end else if (ctrl_one_ff[tmr16_pkg::C1_FORCE2] && !pwm_on && !opm_on) begin
            out2_ff <= ctrl_one_ff[tmr16_pkg::C1_LVL2];
        end else if (m2 && !pwm_on && !opm_on) begin
            out2_ff <= ctrl_one_ff[tmr16_pkg::C1_LVL2];
        end
    end

    // pin enables gate only the routing, never the compare itself
    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            compare_one_pin_out    <= 1'b0;
            compare_one_pin_oe_out <= 1'b0;
            compare_two_pin_out    <= 1'b0;
            compare_two_pin_oe_out <= 1'b0;
        end else begin
            compare_one_pin_oe_out <= ctrl_two_ff[tmr16_pkg::C2_PIN1] && !disable_ff;
            compare_two_pin_oe_out <= ctrl_two_ff[tmr16_pkg::C2_PIN2] && !disable_ff;
            compare_one_pin_out    <= out1_ff;
            compare_two_pin_out    <= out2_ff;
        end
    end

    // ==========================================================
    // interrupt request, also the wait mode wake-up source
    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            timer_irq_out <= 1'b0;
        end else begin
            timer_irq_out <= (ctrl_one_ff[tmr16_pkg::C1_CAP_IE] && (flags.cap_one || flags.cap_two))
                           || (ctrl_one_ff[tmr16_pkg::C1_CMP_IE] && (flags.cmp_one || flags.cmp_two))
                           || (ctrl_one_ff[tmr16_pkg::C1_OVF_IE] && flags.ovf);
        end
    end

    // ==========================================================
    // read data
    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            hrdata_out <= 32'h0000_0000;
        end else if (rd) begin
            hrdata_out <= 32'h0000_0000;
            if (hit(haddr_in[7:0], tmr16_pkg::CTRL_ONE_OFF)) begin
                hrdata_out[7:0] <= ctrl_one_ff;
            end else if (hit(haddr_in[7:0], tmr16_pkg::CTRL_TWO_OFF)) begin
                hrdata_out[7:0] <= ctrl_two_ff;
            end else if (hit(haddr_in[7:0], tmr16_pkg::STATUS_OFF)) begin
                hrdata_out[7:0] <= {flags, disable_ff, 2'h0};
            end else if (hit(haddr_in[7:0], tmr16_pkg::CAP_ONE_HI_OFF)) begin
                hrdata_out[7:0] <= cap_one_ff[15:8];
            end else if (hit(haddr_in[7:0], tmr16_pkg::CAP_ONE_LO_OFF)) begin
                hrdata_out[7:0] <= cap_one_ff[7:0];
            end else if (hit(haddr_in[7:0], tmr16_pkg::CMP_ONE_HI_OFF)) begin
                hrdata_out[7:0] <= cmp_one_ff[15:8];
            end else if (hit(haddr_in[7:0], tmr16_pkg::CMP_ONE_LO_OFF)) begin
                hrdata_out[7:0] <= cmp_one_ff[7:0];
            end else if (hit(haddr_in[7:0], tmr16_pkg::CMP_TWO_HI_OFF)) begin
                hrdata_out[7:0] <= cmp_two_ff[15:8];
            end else if (hit(haddr_in[7:0], tmr16_pkg::CMP_TWO_LO_OFF)) begin
                hrdata_out[7:0] <= cmp_two_ff[7:0];
            end else if (hit(haddr_in[7:0], tmr16_pkg::CNT_HI_OFF)) begin
                hrdata_out[7:0] <= cnt_ff[15:8];
            end else if (hit(haddr_in[7:0], tmr16_pkg::CNT_LO_OFF)) begin
                hrdata_out[7:0] <= cnt_ff[7:0];
            end else if (hit(haddr_in[7:0], tmr16_pkg::CAP_TWO_HI_OFF)) begin
                hrdata_out[7:0] <= cap_two_ff[15:8];
            end else if (hit(haddr_in[7:0], tmr16_pkg::CAP_TWO_LO_OFF)) begin
                hrdata_out[7:0] <= cap_two_ff[7:0];
            end else if (hit(haddr_in[7:0], tmr16_pkg::POWER_OFF)) begin
                hrdata_out[1:0] <= power_ff;
            end
        end
    end

    // zero wait states, always OKAY
    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            hreadyout_out <= 1'b1;
            hresp_out     <= 1'b0;
        end else begin
            hreadyout_out <= 1'b1;
            hresp_out     <= 1'b0;
        end
    end

    // wait mode input is accepted but intentionally changes nothing
    logic unused_ok;
    assign unused_ok = &{1'b0, wait_mode_in, power_ff[tmr16_pkg::PW_WAIT], hsize_in, haddr_in[31:8], hwdata_in[31:8]};
endmodule
`default_nettype wire

/* rtl/tmr16_pkg.sv */
`default_nettype none
package tmr16_pkg;
    // ==========================================================
    // register byte addresses (one aligned word each)
    localparam logic [7:0] CTRL_ONE_OFF     = 8'h00;
    localparam logic [7:0] CTRL_TWO_OFF     = 8'h04;
    localparam logic [7:0] STATUS_OFF       = 8'h08;
    localparam logic [7:0] CAP_ONE_HI_OFF   = 8'h0c;
    localparam logic [7:0] CAP_ONE_LO_OFF   = 8'h10;
    localparam logic [7:0] CMP_ONE_HI_OFF   = 8'h14;
    localparam logic [7:0] CMP_ONE_LO_OFF   = 8'h18;
    localparam logic [7:0] CMP_TWO_HI_OFF   = 8'h1c;
    localparam logic [7:0] CMP_TWO_LO_OFF   = 8'h20;
    localparam logic [7:0] CNT_HI_OFF       = 8'h24;
    localparam logic [7:0] CNT_LO_OFF       = 8'h28;
    localparam logic [7:0] CAP_TWO_HI_OFF   = 8'h2c;
    localparam logic [7:0] CAP_TWO_LO_OFF   = 8'h30;
    localparam logic [7:0] POWER_OFF        = 8'h34;
    // ==========================================================
    // field positions
    localparam int C1_CAP_IE = 7;
    localparam int C1_CMP_IE = 6;
    localparam int C1_OVF_IE = 5;
    localparam int C1_FORCE2 = 4;
    localparam int C1_FORCE1 = 3;
    localparam int C1_LVL2   = 2;
    localparam int C1_EDGE1  = 1;
    localparam int C1_LVL1   = 0;
    localparam int C2_PIN1   = 7;
    localparam int C2_PIN2   = 6;
    localparam int C2_OPM    = 5;
    localparam int C2_PWM    = 4;
    localparam int C2_CLK_HI = 3;
    localparam int C2_CLK_LO = 2;
    localparam int C2_EDGE2  = 1;
    localparam int C2_XEDGE  = 0;
    localparam int PW_WAIT   = 0;
    localparam int PW_HALT   = 1;
    // ==========================================================
    // reset values and constants
    localparam logic [7:0]  CTRL_RST     = 8'h00;
    localparam logic [15:0] CMP_RST      = 16'h8000;
    localparam logic [15:0] CNT_RST      = 16'hfffc;
    localparam logic [15:0] OPM_RELOAD   = 16'hfffc;
    localparam logic [1:0]  CLK_DIV4     = 2'h0;
    localparam logic [1:0]  CLK_DIV2     = 2'h1;
    localparam logic [1:0]  CLK_DIV8     = 2'h2;
    localparam logic [1:0]  CLK_EXT      = 2'h3;
    localparam logic [1:0]  HTRANS_NSEQ  = 2'h2;

    typedef struct packed {
        logic cap_one;
        logic cmp_one;
        logic ovf;
        logic cap_two;
        logic cmp_two;
    } flags_s;
endpackage
`default_nettype wire

/* rtl/tmr16_edge.sv */
`default_nettype none
// ==========================================================
// selectable edge detector on a synchronous input
module tmr16_edge (
    input  wire logic ref_clk_in,
    input  wire logic srst_in,
    input  wire logic sig_in,
    input  wire logic rise_in,
    output logic      hit_out
);
    logic prev_ff;

    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            prev_ff <= 1'b0;
        end else begin
            prev_ff <= sig_in;
        end
    end

    assign hit_out = rise_in ? (sig_in & ~prev_ff) : (~sig_in & prev_ff);
endmodule
`default_nettype wire

/* rtl/tmr16_flag.sv */
`default_nettype none
// ==========================================================
// sticky status flag: set wins over clear, clear needs arm
module tmr16_flag (
    input  wire logic ref_clk_in,
    input  wire logic srst_in,
    input  wire logic set_in,
    input  wire logic status_rd_in,
    input  wire logic low_acc_in,
    output logic      flag_out
);
    logic armed_ff;
    logic flag_ff;

    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            armed_ff <= 1'b0;
        end else if (status_rd_in && flag_ff) begin
            armed_ff <= 1'b1;
        end else if (low_acc_in || !flag_ff) begin
            armed_ff <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            flag_ff <= 1'b0;
        end else if (set_in) begin
            flag_ff <= 1'b1;
        end else if (low_acc_in && armed_ff) begin
            flag_ff <= 1'b0;
        end
    end

    assign flag_out = flag_ff;
endmodule
`default_nettype wire

/* testbench/tmr16_timer_monitor.sv */
`default_nettype none
// ==========================================================
// port checks against a bus-side copy of the control registers
module tmr16_timer_monitor #(
    parameter bit HAS_EXT_PIN = 1'b1
) (
    input wire logic        ref_clk_in,
    input wire logic        srst_in,
    input wire logic        hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0]  htrans_in,
    input wire logic        hwrite_in,
    input wire logic [31:0] hwdata_in,
    input wire logic        hready_in,
    input wire logic [31:0] hrdata_out,
    input wire logic        hreadyout_out,
    input wire logic        hresp_out,
    input wire logic        halt_mode_in,
    input wire logic        compare_one_pin_out,
    input wire logic        compare_one_pin_oe_out,
    input wire logic        compare_two_pin_out,
    input wire logic        compare_two_pin_oe_out,
    input wire logic        timer_irq_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic       wr_ff;
    logic [7:0] wa_ff;
    logic [7:0] c1_ff;
    logic [7:0] c2_ff;
    logic [1:0] age_ff;
    wire logic  take = hsel_in && hready_in && htrans_in == tmr16_pkg::HTRANS_NSEQ;

    always_ff @(posedge ref_clk_in) begin
        wr_ff <= !srst_in && take && hwrite_in;
        wa_ff <= haddr_in[7:0];
    end
    // age gives the registered outputs time to follow a control write
    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            c1_ff <= 8'h00;
            c2_ff <= 8'h00;
            age_ff <= 2'h0;
        end else if (wr_ff && wa_ff == tmr16_pkg::CTRL_ONE_OFF) begin
            c1_ff <= hwdata_in[7:0];
            age_ff <= 2'h0;
        end else if (wr_ff && wa_ff == tmr16_pkg::CTRL_TWO_OFF) begin
            c2_ff <= hwdata_in[7:0];
            age_ff <= 2'h0;
        end else if (age_ff != 2'h3) begin
            age_ff <= age_ff + 2'h1;
        end
    end
    // ==========================================================
    // assertions
    default clocking @(posedge ref_clk_in);
    endclocking
    default disable iff (srst_in);
    sequence s_rd(logic [7:0] a);
        take && !hwrite_in && haddr_in[7:0] == a;
    endsequence
    AST_BUS_OKAY: assert property (hreadyout_out && !hresp_out)
        else $error("slave stalled or answered with an error");
    AST_UPPER_ZERO: assert property (hrdata_out[31:8] == 24'h0)
        else $error("read data above the byte is not zero");
    AST_RESET_QUIET: assert property ($fell(srst_in) |-> !timer_irq_out && !compare_one_pin_oe_out)
        else $error("outputs active right after reset");
    AST_CTRL_ONE_READ: assert property (s_rd(tmr16_pkg::CTRL_ONE_OFF) |=> hrdata_out[7:0] == c1_ff)
        else $error("first control register read back wrong");
    AST_CTRL_TWO_READ: assert property (s_rd(tmr16_pkg::CTRL_TWO_OFF) |=> hrdata_out[7:0] == c2_ff)
        else $error("second control register read back wrong");
    AST_PIN_OWNER: assert property (age_ff == 2'h3 && !halt_mode_in |->
        compare_one_pin_oe_out == c2_ff[7] && compare_two_pin_oe_out == c2_ff[6])
        else $error("pin ownership does not follow the enables");
    AST_FORCE_ONE: assert property (age_ff == 2'h3 && !halt_mode_in && c1_ff[3] && c2_ff[7] && c2_ff[5:4] == 2'h0
        |-> compare_one_pin_out == c1_ff[0])
        else $error("forced level one missing on pin one");
    AST_FORCE_TWO: assert property (age_ff == 2'h3 && !halt_mode_in && c1_ff[4] && c2_ff[6] && c2_ff[5:4] == 2'h0
        |-> compare_two_pin_out == c1_ff[2])
        else $error("forced level two missing on pin two");
    AST_IRQ_INHIBIT: assert property (age_ff == 2'h3 && c1_ff[7:5] == 3'h0 |-> !timer_irq_out)
        else $error("interrupt raised with all sources disabled");
    AST_IRQ_CAUSE: assert property ($rose(timer_irq_out) |-> c1_ff[7:5] != 3'h0)
        else $error("interrupt rose without any enable");
endmodule
bind tmr16_timer tmr16_timer_monitor #(.HAS_EXT_PIN(HAS_EXT_PIN)) mon_u (.ref_clk_in, .srst_in, .hsel_in,
    .haddr_in, .htrans_in, .hwrite_in, .hwdata_in, .hready_in, .hrdata_out, .hreadyout_out, .hresp_out,
    .halt_mode_in, .compare_one_pin_out, .compare_one_pin_oe_out, .compare_two_pin_out,
    .compare_two_pin_oe_out, .timer_irq_out);
`default_nettype wire

/* testbench/sixteen_bit_timer_control_tb_top.sv */
`default_nettype none
module sixteen_bit_timer_control_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk, srst, hwrite, hrdy, hresp, cap1, cap2, ext, halt, wmode, p1, p2, oe1, oe2, irq;
    logic [1:0]  htrans;
    logic [31:0] haddr, hwdata, hrdata, rdata;
    int          err_count, tests_run;

    tmr16_timer dut_u (.ref_clk_in(clk), .srst_in(srst), .hsel_in(1'b1), .haddr_in(haddr), .htrans_in(htrans),
        .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata), .hready_in(hrdy), .hrdata_out(hrdata),
        .hreadyout_out(hrdy), .hresp_out(hresp), .capture_one_pin_in(cap1), .capture_two_pin_in(cap2),
        .external_count_pin_in(ext), .wait_mode_in(wmode), .halt_mode_in(halt), .compare_one_pin_out(p1),
        .compare_one_pin_oe_out(oe1), .compare_two_pin_out(p2), .compare_two_pin_oe_out(oe2), .timer_irq_out(irq));
    // ==========================================================
    // bus and check tasks
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        tests_run++;
        if (s !== e) begin
            err_count++;
            $display("unexpected at %0t: saw %h, expected %h", $time, s, e);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    // entered just after an edge; waits on hready, assumes no latency
    task automatic bus(input logic [7:0] a, input logic w, input logic [7:0] d);
        htrans <= tmr16_pkg::HTRANS_NSEQ;
        haddr <= {24'h0, a};
        hwrite <= w;
        @(posedge clk);
        while (hrdy !== 1'b1) @(posedge clk);
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        @(posedge clk);
        while (hrdy !== 1'b1) @(posedge clk);
        rdata = hrdata;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        bus(a, 1'b0, 8'h00);
        chk(rdata, e);
    endtask
    task automatic tog(input int n);
        repeat (n) begin
            ext <= 1'b1;
            cyc(4);
            ext <= 1'b0;
            cyc(4);
        end
    endtask
    task automatic stop_test;
        if (err_count == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // ==========================================================
    // clock, watchdog, tests
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        cyc(3000);
        err_count++;
        stop_test;
    end
    initial begin
        {cap1, cap2, ext, halt, wmode, hwrite, srst} = 7'h01;
        {htrans, haddr, hwdata} = 66'h0;
        cyc(10);
        srst <= 1'b0;
        cyc(1);
        rd(tmr16_pkg::CTRL_ONE_OFF, 32'h0);
        rd(tmr16_pkg::CTRL_TWO_OFF, 32'h0);
        rd(8'h3c, 32'h0);
        // pins to the timer, external count on rising, capture two on falling
        bus(tmr16_pkg::CTRL_TWO_OFF, 1'b1, 8'hcd);
        bus(tmr16_pkg::CTRL_ONE_OFF, 1'b1, 8'h1d);
        cyc(4);
        chk({oe1, oe2, p1, p2}, 32'hf);
        bus(tmr16_pkg::CTRL_ONE_OFF, 1'b1, 8'h18);
        cyc(4);
        chk({oe1, oe2, p1, p2}, 32'hc);
        rd(tmr16_pkg::CTRL_ONE_OFF, 32'h18);
        wmode <= 1'b1;
        bus(tmr16_pkg::CNT_LO_OFF, 1'b1, 8'h00);
        tog(3);
        rd(tmr16_pkg::CNT_LO_OFF, 32'hff);
        wmode <= 1'b0;
        cap2 <= 1'b1;
        halt <= 1'b1;
        cyc(4);
        cap2 <= 1'b0;
        tog(2);
        rd(tmr16_pkg::STATUS_OFF, 32'h0);
        rd(tmr16_pkg::CNT_LO_OFF, 32'hff);
        halt <= 1'b0;
        cyc(4);
        rd(tmr16_pkg::STATUS_OFF, 32'h10);
        rd(tmr16_pkg::CAP_TWO_LO_OFF, 32'hff);
        tog(1);
        bus(tmr16_pkg::CTRL_ONE_OFF, 1'b1, 8'h20);
        cyc(4);
        chk(irq, 32'h1);
        rd(tmr16_pkg::STATUS_OFF, 32'h20);
        rd(tmr16_pkg::CNT_LO_OFF, 32'h0);
        cyc(4);
        chk(irq, 32'h0);
        bus(tmr16_pkg::CTRL_ONE_OFF, 1'b1, 8'h82);
        cap1 <= 1'b1;
        cyc(6);
        chk(irq, 32'h1);
        rd(tmr16_pkg::STATUS_OFF, 32'h80);
        rd(tmr16_pkg::CAP_ONE_LO_OFF, 32'h0);
        cyc(4);
        chk(irq, 32'h0);
        bus(tmr16_pkg::CMP_ONE_HI_OFF, 1'b1, 8'h00);
        bus(tmr16_pkg::CMP_ONE_LO_OFF, 1'b1, 8'h01);
        bus(tmr16_pkg::CTRL_ONE_OFF, 1'b1, 8'h83);
        tog(2);
        chk(p1, 32'h1);
        stop_test;
    end
endmodule
`default_nettype wire
